// [include/jtsr_regs.svh]
// Register map, field positions and codes of the scan port
`ifndef JTSR_REGS_SVH
`define JTSR_REGS_SVH
`define JTSR_IR_W          3
`define JTSR_IR_EXTEST     3'h0
`define JTSR_IR_IDCODE     3'h1
`define JTSR_IR_SAMPLEZ    3'h2
`define JTSR_IR_SAMPLE     3'h4
`define JTSR_IR_BYPASS     3'h7
`define JTSR_IR_CAPTURE    3'h1
`define JTSR_ID_W          32
`define JTSR_ID_REV_MSB    31
`define JTSR_ID_REV_LSB    29
`define JTSR_ID_CFG_MSB    28
`define JTSR_ID_CFG_LSB    12
`define JTSR_ID_VEN_MSB    11
`define JTSR_ID_VEN_LSB    1
`define JTSR_ID_START      1'h1
`define JTSR_BSR_LEN       109
`define JTSR_BSR_CTRL_BIT  108
`define JTSR_TLR_ONES      5
`endif

// [include/jtsr_pkg.sv]
// Types of the scan port
package jtsr_pkg;
  typedef enum logic [15:0] {
    JTSR_TLR  = 16'h0001, JTSR_RTI  = 16'h0002, JTSR_SDRS = 16'h0004,
    JTSR_CDR  = 16'h0008, JTSR_SDR  = 16'h0010, JTSR_E1DR = 16'h0020,
    JTSR_PDR  = 16'h0040, JTSR_E2DR = 16'h0080, JTSR_UDR  = 16'h0100,
    JTSR_SIRS = 16'h0200, JTSR_CIR  = 16'h0400, JTSR_SIR  = 16'h0800,
    JTSR_E1IR = 16'h1000, JTSR_PIR  = 16'h2000, JTSR_E2IR = 16'h4000,
    JTSR_UIR  = 16'h8000
  } jtsr_state_t;
  typedef enum logic [1:0] {
    JTSR_SEL_BSR = 2'h0, JTSR_SEL_ID = 2'h1, JTSR_SEL_BYP = 2'h2
  } jtsr_sel_t;
endpackage

// [rtl/jtsr_tap.sv]
// Test access port with identification, bypass and boundary scan registers
`timescale 1ns/10ps
`include "jtsr_regs.svh"

// Behaviour
// [R1] Code 001 puts the 32-bit identification register between TDI and TDO.
// [R2] Code 010 selects the boundary chain and floats the data outputs.
// [R3] Code 100 samples the pins into the boundary chain and preloads it.
// [R4] Code 111 places the one-bit bypass register in the path.
// [R5] Code 000 runs external test with the boundary chain in the path.
// [R6] The controller never loads codes 011, 101 or 110; here they select bypass and raise test_mode.
// [R7] Identification bits 11:1 hold the vendor code and bit 0 is always one.
// [R8] Identification bits 31:29 hold the revision number.
// [R9] Identification bits 28:12 hold the part configuration.
// [R10] The configuration field holds flag bits and density and width codes.
// [R11] The chain has 109 cells and the last is an internal control cell set only by scan.
// [R12] Cells on unconnected balls capture a fixed zero and are don't-care.
// [R13] Five TMS-high rising edges or power-up reset the controller.
// [R14] Capture-IR loads 01 into the two low instruction bits.
// [R15] After reset the instruction register holds the identification code.
// [R16] In external test the latched control cell enables outputs when high.
// [R17] The sixteen-state controller samples on rising TCK and drives TDO on falling.
module jtsr_tap #(
  parameter int          BSR_LEN  = `JTSR_BSR_LEN,
  // Arbitrary identification values
  parameter logic [2:0]  REV_ID   = 3'h0,
  parameter logic [16:0] PART_CFG = 17'h00000,
  parameter logic [10:0] VENDOR   = 11'h000,
  parameter logic [BSR_LEN-2:0] NC_MASK = '0
) (
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire logic                 tck,
  input  wire logic                 tms,
  input  wire logic                 tdi,
  output logic                      tdo,
  output logic                      tdo_oe,
  input  wire logic [BSR_LEN-2:0]   pin_in,
  output logic      [BSR_LEN-2:0]   pin_out,
  output logic                      pin_drive,
  output logic                      test_mode,
  output logic      [BSR_LEN-2:0]   cap_data,
  output logic                      cap_valid,
  input  wire logic                 cap_ready
);
  import jtsr_pkg::*;

  // Chain length is fixed by the cell order
  if (BSR_LEN != `JTSR_BSR_LEN) begin : g_bad_len
    $error("BSR_LEN must be 109");
  end

  // ****************************************
  // Controller state
  // ****************************************
  jtsr_state_t st_q, st_d;
  logic [`JTSR_IR_W-1:0] ir_sh_q, ir_q;
  logic [`JTSR_ID_W-1:0] id_sh_q;
  logic                  byp_q;
  logic [BSR_LEN-1:0]    bsr_sh_q, bsr_upd_q;
  logic                  tdo_q, tdo_oe_q;
  logic                  rst_tck_q1, rst_tck_q2;

  // Reset of the link domain, released on the link clock
  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      rst_tck_q1 <= 1'b1;
      rst_tck_q2 <= 1'b1;
    end else begin
      rst_tck_q1 <= 1'b0;
      rst_tck_q2 <= rst_tck_q1;
    end
  end

  // [R17] State transitions
  always_comb begin
    case (st_q)
      JTSR_TLR:  st_d = tms ? JTSR_TLR  : JTSR_RTI;
      JTSR_RTI:  st_d = tms ? JTSR_SDRS : JTSR_RTI;
      JTSR_SDRS: st_d = tms ? JTSR_SIRS : JTSR_CDR;
      JTSR_CDR:  st_d = tms ? JTSR_E1DR : JTSR_SDR;
      JTSR_SDR:  st_d = tms ? JTSR_E1DR : JTSR_SDR;
      JTSR_E1DR: st_d = tms ? JTSR_UDR  : JTSR_PDR;
      JTSR_PDR:  st_d = tms ? JTSR_E2DR : JTSR_PDR;
      JTSR_E2DR: st_d = tms ? JTSR_UDR  : JTSR_SDR;
      JTSR_UDR:  st_d = tms ? JTSR_SDRS : JTSR_RTI;
      JTSR_SIRS: st_d = tms ? JTSR_TLR  : JTSR_CIR;
      JTSR_CIR:  st_d = tms ? JTSR_E1IR : JTSR_SIR;
      JTSR_SIR:  st_d = tms ? JTSR_E1IR : JTSR_SIR;
      JTSR_E1IR: st_d = tms ? JTSR_UIR  : JTSR_PIR;
      JTSR_PIR:  st_d = tms ? JTSR_E2IR : JTSR_PIR;
      JTSR_E2IR: st_d = tms ? JTSR_UIR  : JTSR_SIR;
      JTSR_UIR:  st_d = tms ? JTSR_SDRS : JTSR_RTI;
      default:   st_d = JTSR_TLR;
    endcase
  end

  // [R13] Power-up reset; five TMS highs reach TLR from any state
  always_ff @(posedge tck or posedge rst_tck_q2) begin
    if (rst_tck_q2) st_q <= JTSR_TLR;
    else            st_q <= st_d;
  end

  // ****************************************
  // Instruction decode
  // ****************************************
  function automatic jtsr_sel_t dec_sel(input logic [2:0] ir);
    case (ir)
      `JTSR_IR_EXTEST, `JTSR_IR_SAMPLEZ, `JTSR_IR_SAMPLE: dec_sel = JTSR_SEL_BSR;
      `JTSR_IR_IDCODE: dec_sel = JTSR_SEL_ID;
      default:         dec_sel = JTSR_SEL_BYP;
    endcase
  endfunction

  // [R1] [R2] [R3] [R4] [R5] Path selection
  wire jtsr_sel_t sel       = dec_sel(ir_q);
  wire            is_extest = (ir_q == `JTSR_IR_EXTEST);
  wire            is_samplz = (ir_q == `JTSR_IR_SAMPLEZ);
  // [R6] Reserved codes fall to bypass
  wire            is_rsvd   = (sel == JTSR_SEL_BYP) && (ir_q != `JTSR_IR_BYPASS);
  // [R7] [R8] [R9] [R10] Identification word
  wire [`JTSR_ID_W-1:0] id_word = {REV_ID, PART_CFG, VENDOR, `JTSR_ID_START};
  // [R12] Unconnected cells capture zero
  wire [BSR_LEN-2:0]    pin_cap = pin_in & ~NC_MASK;

  // ****************************************
  // Instruction register
  // ****************************************
  always_ff @(posedge tck or posedge rst_tck_q2) begin
    if (rst_tck_q2) begin
      ir_sh_q <= `JTSR_IR_IDCODE;
      ir_q    <= `JTSR_IR_IDCODE;
    end else begin
      // [R14] Capture pattern 01
      if (st_q == JTSR_CIR) ir_sh_q <= {ir_sh_q[2], 2'b01};
      else if (st_q == JTSR_SIR) ir_sh_q <= {tdi, ir_sh_q[2:1]};
      // [R15] Reset loads identification code
      if (st_q == JTSR_TLR) ir_q <= `JTSR_IR_IDCODE;
      else if (st_q == JTSR_UIR) ir_q <= ir_sh_q;
    end
  end

  // ****************************************
  // Data registers
  // ****************************************
  wire cdr = (st_q == JTSR_CDR);
  wire sdr = (st_q == JTSR_SDR);

  always_ff @(posedge tck or posedge rst_tck_q2) begin
    if (rst_tck_q2) begin
      id_sh_q <= '0;
      byp_q   <= 1'b0;
    end else begin
      // [R1] Capture and shift identification
      if (cdr && sel == JTSR_SEL_ID) id_sh_q <= id_word;
      else if (sdr && sel == JTSR_SEL_ID) id_sh_q <= {tdi, id_sh_q[31:1]};
      // [R4] Bypass captures zero
      if (cdr) byp_q <= 1'b0;
      else if (sdr) byp_q <= tdi;
    end
  end

  // [R11] Chain of 109 cells; last cell captures its own latched value
  always_ff @(posedge tck or posedge rst_tck_q2) begin
    if (rst_tck_q2) begin
      bsr_sh_q <= '0;
    end else if (cdr && sel == JTSR_SEL_BSR) begin
      bsr_sh_q <= {bsr_upd_q[`JTSR_BSR_CTRL_BIT], pin_cap};
    end else if (sdr && sel == JTSR_SEL_BSR) begin
      bsr_sh_q <= {tdi, bsr_sh_q[BSR_LEN-1:1]};
    end
  end

  // [R16] Update latch cleared in TLR
  always_ff @(posedge tck or posedge rst_tck_q2) begin
    if (rst_tck_q2) bsr_upd_q <= '0;
    else if (st_q == JTSR_TLR) bsr_upd_q <= '0;
    else if (st_q == JTSR_UDR && sel == JTSR_SEL_BSR) bsr_upd_q <= bsr_sh_q;
  end

  // ****************************************
  // Serial output on falling edge
  // ****************************************
  logic tdo_d;
  always_comb begin
    case (st_q)
      JTSR_SIR: tdo_d = ir_sh_q[0];
      JTSR_SDR: begin
        case (sel)
          JTSR_SEL_ID:  tdo_d = id_sh_q[0];
          JTSR_SEL_BSR: tdo_d = bsr_sh_q[0];
          default:      tdo_d = byp_q;
        endcase
      end
      default:  tdo_d = 1'b0;
    endcase
  end

  // [R17] TDO changes on falling TCK
  always_ff @(negedge tck or posedge rst_tck_q2) begin
    if (rst_tck_q2) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q    <= tdo_d;
      tdo_oe_q <= (st_q == JTSR_SIR) || (st_q == JTSR_SDR);
    end
  end

  assign tdo    = tdo_q;
  assign tdo_oe = tdo_oe_q;

  // ****************************************
  // Pin control
  // ****************************************
  // [R2] [R16] Output enable per instruction
  assign pin_out   = bsr_upd_q[BSR_LEN-2:0];
  assign pin_drive = is_extest ? bsr_upd_q[`JTSR_BSR_CTRL_BIT] : ~is_samplz;
  assign test_mode = is_extest | is_rsvd;

  // ****************************************
  // Capture handoff to system clock
  // ****************************************
  logic               cap_tgl_q;
  logic [BSR_LEN-2:0] cap_hold_q;
  // [R3] Sampled pins passed on with a toggle
  always_ff @(posedge tck or posedge rst_tck_q2) begin
    if (rst_tck_q2) begin
      cap_tgl_q  <= 1'b0;
      cap_hold_q <= '0;
    end else if (cdr && sel == JTSR_SEL_BSR) begin
      cap_tgl_q  <= ~cap_tgl_q;
      cap_hold_q <= pin_cap;
    end
  end

  logic tg_q1, tg_q2, tg_q3;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tg_q1 <= 1'b0;
      tg_q2 <= 1'b0;
      tg_q3 <= 1'b0;
    end else begin
      tg_q1 <= cap_tgl_q;
      tg_q2 <= tg_q1;
      tg_q3 <= tg_q2;
    end
  end
  wire cap_evt = tg_q2 ^ tg_q3;

  // Two-entry buffer
  logic [BSR_LEN-2:0] buf_q [2];
  logic [1:0]         cnt_q;
  logic               rd_q, wr_q;
  wire in_ok  = cap_evt && (cnt_q != 2'h2);
  wire out_ok = cap_valid && cap_ready;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 2'h0;
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
    end else begin
      if (in_ok) wr_q <= ~wr_q;
      if (out_ok) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, in_ok} - {1'b0, out_ok};
    end
  end

  always_ff @(posedge mclk) begin
    if (in_ok) buf_q[wr_q] <= cap_hold_q;
  end

  assign cap_valid = (cnt_q != 2'h0);
  assign cap_data  = cap_valid ? buf_q[rd_q] : '0;

endmodule // jtsr_tap

// [verification/jtsr_tap_props.sv]
// Assertions on the scan port pins
`timescale 1ns/10ps
module jtsr_chk #(
  parameter int BSR_LEN = 109
) (
  input wire logic               mclk, sys_rst, tck, tms, tdi, tdo, tdo_oe,
  input wire logic               pin_drive, test_mode, cap_valid, cap_ready,
  input wire logic [BSR_LEN-2:0] pin_in, pin_out, cap_data
);
  logic tdo_hi_q;
  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) tdo_hi_q <= 1'b0;
    else tdo_hi_q <= tdo;
  end
  sequence s_five_ones;
    tms [*5];
  endsequence
  property p_five;
    @(posedge tck) disable iff (sys_rst) s_five_ones |-> ##2 (!test_mode && pin_drive);
  endproperty
  a_five_ones: assert property (p_five)
    else $error("five ones did not reset");
  a_tdo_steady: assert property (@(negedge tck) disable iff (sys_rst) tdo == tdo_hi_q)
    else $error("tdo moved while tck high");
  a_oe_enter: assert property (@(posedge tck) disable iff (sys_rst)
    $rose(tdo_oe) |-> !$past(tms)) else $error("oe rose without shift entry");
  a_oe_stay: assert property (@(posedge tck) disable iff (sys_rst)
    tdo_oe && !tms |=> tdo_oe) else $error("oe dropped inside shift");
  a_oe_exit: assert property (@(posedge tck) disable iff (sys_rst)
    tdo_oe && tms |=> !tdo_oe) else $error("oe held after shift exit");
  a_mode_change: assert property (@(posedge tck) disable iff (sys_rst)
    $changed(test_mode) |-> $past(tms) || $past(tms, 2)) else $error("mode changed early");
  a_valid_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    cap_valid && !cap_ready |=> cap_valid && $stable(cap_data)) else $error("word lost");
  a_reset_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(sys_rst) |-> !cap_valid && !tdo_oe && pin_drive && !test_mode)
    else $error("bad state after reset");
endmodule // jtsr_chk
bind jtsr_tap jtsr_chk #(.BSR_LEN(BSR_LEN)) jtsr_chk_i (.mclk(mclk), .sys_rst(sys_rst),
  .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_drive(pin_drive),
  .test_mode(test_mode), .cap_valid(cap_valid), .cap_ready(cap_ready), .pin_in(pin_in),
  .pin_out(pin_out), .cap_data(cap_data));

// [verification/jtsr_ctrl_mdl.sv]
// Scan controller model driving the port pins
`timescale 1ns/10ps
module jtsr_ctrl_mdl (
  output logic      tck, tms, tdi,
  input wire logic  tdo
);
  logic q;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #16 q = tdo;
    tck = 1'b1;
    #16 tck = 1'b0;
  endtask
  task automatic reset_tap;
    repeat (5) step(1'b1, tdi);
    step(1'b0, tdi);
  endtask
  task automatic scan(input logic ir, input int n, input logic [109:0] din,
                      output logic [109:0] dout);
    dout = '0;
    step(1'b1, tdi);
    if (ir) step(1'b1, tdi);
    step(1'b0, tdi);
    step(1'b0, tdi);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i]);
      dout[i] = q;
    end
    step(1'b1, ~tdi);
    step(1'b0, ~tdi);
  endtask
endmodule // jtsr_ctrl_mdl

// [verification/tb_top.sv]
// Testbench for the scan port
`timescale 1ns/10ps
module tb_top;
  typedef struct packed {
    logic [2:0] c;
    logic       tm;
    logic       pd;
    logic [6:0] n;
  } jtsr_row_t;
  logic         mclk, sys_rst, cap_ready, tck, tms, tdi, tdo, tdo_oe;
  logic         pin_drive, test_mode, cap_valid;
  logic [107:0] pin_in, pin_out, cap_data, pv [3];
  logic [109:0] o;
  int           err_count, comparisons;
  // Arbitrary identification fields and unconnected cells
  localparam logic [107:0] NC = 108'h3;
  localparam logic [31:0]  ID = {3'h5, 17'h1abcd, 11'h2a5, 1'b1};
  jtsr_row_t    rows [8] = '{'{3'h0, 1'b1, 1'b0, 7'd109}, '{3'h1, 1'b0, 1'b1, 7'd32},
    '{3'h2, 1'b0, 1'b0, 7'd109}, '{3'h3, 1'b1, 1'b1, 7'd1}, '{3'h4, 1'b0, 1'b1, 7'd109},
    '{3'h5, 1'b1, 1'b1, 7'd1}, '{3'h6, 1'b1, 1'b1, 7'd1}, '{3'h7, 1'b0, 1'b1, 7'd1}};
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  jtsr_tap #(.BSR_LEN(109), .REV_ID(3'h5), .PART_CFG(17'h1abcd), .VENDOR(11'h2a5),
    .NC_MASK(NC)) jtsr_tap_i (.mclk(mclk), .sys_rst(sys_rst), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .pin_out(pin_out),
    .pin_drive(pin_drive), .test_mode(test_mode), .cap_data(cap_data),
    .cap_valid(cap_valid), .cap_ready(cap_ready));
  jtsr_ctrl_mdl jtsr_ctrl_mdl_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  task automatic chk(input string s, input logic [107:0] e, input logic [107:0] v);
    comparisons++;
    if (v !== e) begin
      $display("Error %s expected %h seen %h", s, e, v);
      err_count++;
    end
  endtask
  task automatic results;
    $display("Counts: %0d compared, %0d mismatched", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rst;
    @(negedge mclk) sys_rst = 1'b1;
    fork
      repeat (2) jtsr_ctrl_mdl_i.step(1'b1, 1'b0);
    join_none
    repeat (10) @(negedge mclk);
    chk("reset outs", 4'b0001, {tdo_oe, cap_valid, test_mode, pin_drive});
    sys_rst = 1'b0;
    repeat (2) jtsr_ctrl_mdl_i.step(1'b1, 1'b0);
    jtsr_ctrl_mdl_i.step(1'b0, 1'b0);
    $display("Reset done");
  endtask
  task automatic ir(input logic [2:0] c);
    jtsr_ctrl_mdl_i.scan(1'b1, 3, 110'(c), o);
    chk("ir capture", 2'b01, o[1:0]);
  endtask
  initial begin
    sys_rst = 1'b1;
    cap_ready = 1'b0;
    pin_in = '0;
    err_count = 0;
    comparisons = 0;
    rst();
    foreach (rows[i]) begin
      pin_in = {27{4'(i) + 4'h9}};
      if (rows[i].n == 109 && i < 4) pv[i / 2] = pin_in & ~NC;
      ir(rows[i].c);
      chk("mode", {rows[i].tm, rows[i].pd}, {test_mode, pin_drive});
      jtsr_ctrl_mdl_i.scan(1'b0, 110, 110'h1, o);
      chk("length", 1, o[rows[i].n]);
      if (rows[i].n == 32) chk("id", ID, o[31:0]);
      if (rows[i].n == 109) chk("pins", pin_in & ~NC, o[107:0]);
      if (rows[i].n == 109) chk("ctrl cell", 0, o[108]);
      if (rows[i].n == 1) chk("bypass", 0, o[0]);
      $display("Row %0d done", i);
    end
    for (int k = 0; k < 2; k++) begin
      for (int t = 0; t < 50 && cap_valid !== 1'b1; t++) @(negedge mclk);
      chk("valid", 1, cap_valid);
      chk("buffer", pv[k], cap_data);
      @(negedge mclk) cap_ready = 1'b1;
      @(negedge mclk) cap_ready = 1'b0;
    end
    repeat (8) @(negedge mclk);
    chk("drop", 0, cap_valid);
    ir(3'h4);
    jtsr_ctrl_mdl_i.scan(1'b0, 110, {1'b1, {27{4'ha}}, 1'b0}, o);
    ir(3'h0);
    chk("extest", 2'b11, {test_mode, pin_drive});
    chk("preload", {27{4'ha}}, pin_out);
    ir(3'h2);
    chk("float", 0, pin_drive);
    jtsr_ctrl_mdl_i.reset_tap();
    chk("tms reset", 2'b01, {test_mode, pin_drive});
    ir(3'h0);
    chk("cell clear", 2'b10, {test_mode, pin_drive});
    rst();
    jtsr_ctrl_mdl_i.scan(1'b0, 32, 110'h0, o);
    chk("id reset", ID, o[31:0]);
    results();
  end
endmodule // tb_top
